// *** design/phsr_top.sv ***
// Rule encoding parser, rule store and error encoding builder
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phsr_consts.svh"
module phsr_top
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_txn_start,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_rx_ready,
  output logic o_err_valid,
  output logic [7:0] o_err_data,
  output logic o_err_last,
  input wire logic i_err_ready,
  output logic [1:0] o_err_rsp_kind,
  output logic o_rsp_echo_inhibit,
  output logic [3:0] o_suppress_en
);
  import phsr_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    phsr_state_e st;
    logic [1:0] ph;
    logic [7:0] sub;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [8:0] tot;
    logic [31:0] val;
    logic [7:0] cref;
    logic [15:0] cid;
    logic [15:0] sfref;
    logic [31:0] sfid;
    logic [7:0] act;
    logic h_cid;
    logic h_sfid;
    logic h_hdr;
    logic h_cnt;
    logic [7:0] scnt;
    logic [7:0] bad_sub;
    logic [7:0] bad_code;
    phsr_rule_s [3:0] rules;
    logic [2:0] ctrl;
    logic txn_err;
    logic [7:0] last_code;
    logic [7:0] last_sub;
    logic [15:0] n_ok;
    logic [15:0] n_rej;
    logic [63:0] ebuf;
    logic [2:0] eidx;
    logic [31:0] prdata;
    logic pslverr;
  } phsr_st_s;

  phsr_st_s r_reg;
  phsr_st_s r_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Lookup of a rule by classifier and flow; returns {hit, index}
  function automatic logic [2:0] phsr_find(input phsr_rule_s [3:0] rl,
    input logic [15:0] cid, input logic [31:0] sfid);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (rl[i].valid && rl[i].cid == cid && rl[i].sfid == sfid)
      begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // First free slot; {found, index}
  function automatic logic [2:0] phsr_free(input phsr_rule_s [3:0] rl);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (!rl[i].valid)
      begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // Length and range check of one subtype; nonzero means reject
  function automatic logic [7:0] phsr_chk(input logic [7:0] sub,
    input logic [7:0] len, input logic [31:0] v);
    logic [7:0] cc;
    cc = 8'h00;
    case (sub)
      `PHSR_SUB_CREF:
        if (len != 8'h01 || v == 32'h0) cc = `PHSR_CC_UNRECOG; //RULE2
      `PHSR_SUB_CID:
        if (len != 8'h02 || v == 32'h0) cc = `PHSR_CC_UNRECOG; //RULE3
      `PHSR_SUB_SFREF:
        if (len != 8'h02 || v == 32'h0) cc = `PHSR_CC_UNRECOG; //RULE4
      `PHSR_SUB_SFID:
        if (len != 8'h04 || v == 32'h0) cc = `PHSR_CC_UNRECOG; //RULE5
      `PHSR_SUB_ACT:
        if (len != 8'h01 || v > 32'h3) cc = `PHSR_CC_UNRECOG; //RULE25
      `PHSR_SUB_CNT: if (len != 8'h01) cc = `PHSR_CC_UNRECOG;
      `PHSR_SUB_ERR: cc = `PHSR_CC_UNRECOG; //RULE17
      default: cc = 8'h00;
    endcase
    return cc;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic fire;
  logic fin;
  logic [31:0] v;
  logic [7:0] cc;
  logic [15:0] key_cid;
  logic [31:0] key_sf;
  logic [2:0] hit;
  logic [2:0] fre;
  logic [7:0] act;
  logic [7:0] ecode;
  logic [7:0] esub;

  assign o_rx_ready = (r_reg.st == PHSR_PARSE);
  assign fire = i_rx_valid && o_rx_ready;
  // Rule keys fall back to the in-message references
  assign key_cid = r_reg.h_cid ? r_reg.cid : {8'h00, r_reg.cref};
  assign key_sf = r_reg.h_sfid ? r_reg.sfid : {16'h0, r_reg.sfref};
  assign hit = phsr_find(r_reg.rules, key_cid, key_sf);
  assign fre = phsr_free(r_reg.rules);
  // Action applies only in a change request; elsewhere it is an add
  assign act = (r_reg.ctrl[1:0] == `PHSR_KIND_DSC) ? r_reg.act
                                                   : `PHSR_ACT_ADD; //RULE6

  always_comb
  begin
    r_next = r_reg;
    fin = 1'b0;
    v = {r_reg.val[23:0], i_rx_data};
    cc = 8'h00;
    ecode = 8'h00;
    esub = 8'h00;
    case (r_reg.st)
      PHSR_IDLE:
      begin
        // Fresh rule set; kind 3 is no valid response context
        if (i_rx_valid && r_reg.ctrl[2] &&
            r_reg.ctrl[1:0] != `PHSR_KIND_BAD) //RULE12
        begin
          r_next.st = PHSR_PARSE;
          r_next.ph = 2'h0;
          r_next.tot = 9'h0;
          r_next.h_cid = 1'b0;
          r_next.h_sfid = 1'b0;
          r_next.h_hdr = 1'b0;
          r_next.h_cnt = 1'b0;
          r_next.cref = 8'h00;
          r_next.sfref = 16'h0;
          r_next.act = `PHSR_ACT_ADD;
          r_next.bad_code = 8'h00;
          r_next.bad_sub = 8'h00;
        end
      end
      PHSR_PARSE:
      begin
        if (fire)
        begin
          r_next.tot = r_reg.tot + 9'h1;
          // Oversized encoding is malformed, report the outer type
          if (r_reg.tot >= `PHSR_RULE_MAXTOT &&
              r_reg.bad_code == 8'h00) //RULE1
          begin
            r_next.bad_code = `PHSR_CC_UNRECOG;
            r_next.bad_sub = `PHSR_TYPE_RULE;
          end
          case (r_reg.ph)
            2'h0:
            begin
              r_next.sub = i_rx_data;
              r_next.ph = 2'h1;
            end
            2'h1:
            begin
              r_next.len = i_rx_data;
              r_next.cnt = 8'h00;
              r_next.val = 32'h0;
              r_next.ph = (i_rx_data == 8'h00) ? 2'h0 : 2'h2;
              fin = (i_rx_data == 8'h00);
              v = 32'h0;
            end
            default:
            begin
              r_next.val = v;
              r_next.cnt = r_reg.cnt + 8'h1;
              fin = (r_reg.cnt + 8'h1 == r_reg.len);
              if (fin)
              begin
                r_next.ph = 2'h0;
              end
            end
          endcase
          if (fin)
          begin
            cc = phsr_chk(r_reg.sub, fin && r_reg.ph == 2'h1 ? 8'h00
                          : r_reg.len, v);
            if (cc != 8'h00 && r_next.bad_code == 8'h00)
            begin
              r_next.bad_code = cc;
              r_next.bad_sub = r_reg.sub;
            end
            case (r_reg.sub)
              `PHSR_SUB_CREF: r_next.cref = v[7:0];
              `PHSR_SUB_CID:
              begin
                r_next.cid = v[15:0];
                r_next.h_cid = 1'b1;
              end
              `PHSR_SUB_SFREF: r_next.sfref = v[15:0];
              `PHSR_SUB_SFID:
              begin
                r_next.sfid = v;
                r_next.h_sfid = 1'b1;
              end
              `PHSR_SUB_ACT: r_next.act = v[7:0];
              `PHSR_SUB_HDR: r_next.h_hdr = (r_reg.ph == 2'h2);
              `PHSR_SUB_CNT:
              begin
                r_next.scnt = v[7:0];
                r_next.h_cnt = 1'b1;
              end
              default: r_next.sub = r_reg.sub;
            endcase
          end
          if (i_rx_last)
          begin
            // A set cut short after a subtype's length byte is malformed
            if (!fin && r_reg.ph != 2'h0 && r_next.bad_code == 8'h00)
            begin
              r_next.bad_code = `PHSR_CC_UNRECOG;
              r_next.bad_sub = r_reg.sub;
            end
            r_next.st = PHSR_EXEC;
          end
        end
      end
      PHSR_EXEC:
      begin
        if (r_reg.bad_code != 8'h00)
        begin
          ecode = r_reg.bad_code;
          esub = r_reg.bad_sub;
        end
        else
        begin
          case (act)
            `PHSR_ACT_ADD:
            begin
              if (hit[2])
              begin
                ecode = `PHSR_CC_EXISTS; //RULE11 RULE23
                esub = `PHSR_SUB_ACT;
              end
              else if (!fre[2])
              begin
                ecode = `PHSR_CC_RESOURCE;
                esub = `PHSR_SUB_ACT;
              end
              else
              begin
                r_next.rules[fre[1:0]] = '{1'b1, r_reg.h_hdr,
                  r_reg.h_cnt, r_reg.scnt, key_cid, key_sf};
              end
            end
            `PHSR_ACT_FILL:
            begin
              if (!hit[2])
              begin
                ecode = `PHSR_CC_NOTFOUND; //RULE23
                esub = `PHSR_SUB_ACT;
              end
              else if (r_reg.rules[hit[1:0]].hdr_k &&
                       r_reg.rules[hit[1:0]].cnt_k) //RULE9
              begin
                ecode = `PHSR_CC_HDRSUP;
                esub = r_reg.h_cnt ? `PHSR_SUB_CNT : `PHSR_SUB_HDR;
              end
              else
              begin
                // Merge only the fields that arrived
                if (r_reg.h_hdr) //RULE8
                begin
                  r_next.rules[hit[1:0]].hdr_k = 1'b1;
                end
                if (r_reg.h_cnt) //RULE8
                begin
                  r_next.rules[hit[1:0]].cnt_k = 1'b1;
                  r_next.rules[hit[1:0]].scnt = r_reg.scnt;
                end
              end
            end
            `PHSR_ACT_DEL:
            begin
              if (!hit[2])
              begin
                ecode = `PHSR_CC_NOTFOUND; //RULE23
                esub = `PHSR_SUB_ACT;
              end
              else
              begin
                r_next.rules[hit[1:0]].valid = 1'b0;
              end
            end
            default:
            begin
              // Delete all rules of the flow
              for (int i = 0; i < 4; i++)
              begin
                if (r_reg.rules[i].sfid == key_sf) //RULE10
                begin
                  r_next.rules[i].valid = 1'b0;
                end
              end
            end
          endcase
        end
        r_next.last_code = ecode;
        r_next.last_sub = esub;
        if (ecode != 8'h00) //RULE20
        begin
          // Error set: code and errored subtype, no text field
          r_next.ebuf = {`PHSR_SUB_ERR, `PHSR_ERR_LEN,
            `PHSR_ESUB_PARAM, 8'h01, esub,
            `PHSR_ESUB_CODE, 8'h01, ecode}; //RULE13 RULE18 RULE19 RULE21
          r_next.eidx = 3'h0;
          r_next.txn_err = 1'b1; //RULE16
          r_next.n_rej = r_reg.n_rej + 16'h1;
          r_next.st = PHSR_EMIT; //RULE14
        end
        else
        begin
          r_next.n_ok = r_reg.n_ok + 16'h1; //RULE15
          r_next.st = PHSR_IDLE;
        end
      end
      PHSR_EMIT:
      begin
        // Eight bytes fixed, far under the 256 limit
        if (i_err_ready) //RULE22
        begin
          r_next.ebuf = {r_reg.ebuf[55:0], 8'h00};
          r_next.eidx = r_reg.eidx + 3'h1;
          if (r_reg.eidx == 3'h7)
          begin
            r_next.st = PHSR_IDLE;
          end
        end
      end
      default: r_next.st = PHSR_IDLE;
    endcase
    // A new transaction clears the error mark unless an error lands now
    if (i_txn_start && !(r_reg.st == PHSR_EXEC && ecode != 8'h00))
    begin
      r_next.txn_err = 1'b0;
    end
    // APB: data latched in setup, writes in access
    if (i_psel && !i_penable)
    begin
      r_next.pslverr = 1'b0;
      case (i_paddr)
        `PHSR_OFS_CTRL: r_next.prdata = {29'h0, r_reg.ctrl};
        `PHSR_OFS_STAT: r_next.prdata = {8'h00, r_reg.last_sub,
          r_reg.last_code, 6'h0, r_reg.txn_err,
          r_reg.st != PHSR_IDLE};
        `PHSR_OFS_RULES: r_next.prdata = {20'h0, o_suppress_en,
          r_reg.rules[3].hdr_k & r_reg.rules[3].cnt_k,
          r_reg.rules[2].hdr_k & r_reg.rules[2].cnt_k,
          r_reg.rules[1].hdr_k & r_reg.rules[1].cnt_k,
          r_reg.rules[0].hdr_k & r_reg.rules[0].cnt_k,
          r_reg.rules[3].valid, r_reg.rules[2].valid,
          r_reg.rules[1].valid, r_reg.rules[0].valid};
        `PHSR_OFS_NOK: r_next.prdata = {16'h0, r_reg.n_ok};
        `PHSR_OFS_NREJ: r_next.prdata = {16'h0, r_reg.n_rej};
        default:
        begin
          r_next.prdata = 32'h0;
          r_next.pslverr = 1'b1;
        end
      endcase
    end
    if (i_psel && i_penable && i_pwrite && i_paddr == `PHSR_OFS_CTRL)
    begin
      r_next.ctrl = i_pwdata[2:0];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Whole state in one flop group; rule store included
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r_reg <= '0;
      r_reg.st <= PHSR_IDLE;
      r_reg.ctrl <= `PHSR_CTRL_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero-wait slave; error answer only on unmapped offsets
  assign o_pready = 1'b1;
  assign o_prdata = r_reg.prdata;
  assign o_pslverr = r_reg.pslverr & i_psel & i_penable;
  assign o_err_valid = (r_reg.st == PHSR_EMIT);
  assign o_err_data = r_reg.ebuf[63:56];
  assign o_err_last = o_err_valid && r_reg.eidx == 3'h7;
  assign o_err_rsp_kind = r_reg.ctrl[1:0];
  assign o_rsp_echo_inhibit = r_reg.txn_err;
  // Suppression runs only for fully defined rules with nonzero count
  for (genvar g = 0; g < 4; g++)
  begin : g_sup
    assign o_suppress_en[g] = r_reg.rules[g].valid &&
      r_reg.rules[g].hdr_k && r_reg.rules[g].cnt_k &&
      r_reg.rules[g].scnt != 8'h00; //RULE7 RULE24
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  a_code_nonzero: assert property (o_err_valid |-> //RULE20
    r_reg.last_code != 8'h00)
    else $error("error set with success code");
  a_err_header: assert property (r_reg.st == PHSR_EXEC && //RULE13
    r_next.st == PHSR_EMIT |=> o_err_data == 8'h06 && r_reg.eidx == 3'h0)
    else $error("error set header wrong");
  a_echo_block: assert property (o_err_valid |-> o_rsp_echo_inhibit) //RULE16
    else $error("error emitted without echo inhibit");
  a_emit_len: assert property (o_err_last && i_err_ready |=> //RULE22
    r_reg.st == PHSR_IDLE && !o_err_valid)
    else $error("error set not eight bytes");
  a_add_exists: assert property (r_reg.st == PHSR_EXEC && //RULE11
    r_reg.bad_code == 8'h00 && act == `PHSR_ACT_ADD && hit[2]
    |=> r_reg.last_code == 8'h11 ##1 o_err_valid)
    else $error("existing rule add not rejected");
  a_act_range: assert property (r_reg.st == PHSR_EXEC && //RULE25
    r_reg.bad_sub == `PHSR_SUB_ACT |=> r_reg.last_sub == 8'h05 &&
    r_reg.last_code == 8'h02 && o_err_valid)
    else $error("bad action not reported");
  a_full_only: assert property (o_suppress_en[0] |-> //RULE24
    r_reg.rules[0].hdr_k && r_reg.rules[0].cnt_k &&
    r_reg.rules[0].scnt != 8'h00)
    else $error("suppression on partial rule");
  a_fill_refuse: assert property (r_reg.st == PHSR_EXEC && //RULE9
    r_reg.bad_code == 8'h00 && act == `PHSR_ACT_FILL && hit[2] &&
    r_reg.rules[hit[1:0]].hdr_k && r_reg.rules[hit[1:0]].cnt_k
    |=> $stable(r_reg.rules) && r_reg.last_code == 8'h09)
    else $error("fill changed a full rule");
  c_reject: cover property (o_err_last && i_err_ready);
  c_accept: cover property (r_reg.st == PHSR_EXEC ##1
    r_reg.st == PHSR_IDLE);
  c_full: cover property ($rose(o_suppress_en[0]));
endmodule // phsr_top
`default_nettype wire

// *** design/phsr_consts.svh ***
// Constants for the header suppression rule command interpreter
// How it works
// RULE1 - Rule encoding is type 26; total length 255 or more is malformed
// RULE2 - Subtype 1 is a one-byte classifier reference, legal 1 to 255
// RULE3 - Subtype 2 is a two-byte classifier identifier, legal 1 to 65535
// RULE4 - Subtype 3 is a two-byte service flow reference, legal 1 to 65535
// RULE5 - Subtype 4 is a four-byte service flow identifier, nonzero
// RULE6 - Subtype 5 action in a change request: add, fill, delete, delete all
// RULE7 - A rule is fully defined once cached bytes and byte count are known
// RULE8 - A fill action adds supplied fields to a partially defined rule
// RULE9 - A fill action on a fully defined rule is refused
// RULE10 - Delete all removes every rule of the named service flow
// RULE11 - Adding a rule that already exists is rejected
// RULE12 - Error encodings go only into registration, add and change responses
// RULE13 - A failure emits an error set with code and errored subtype
// RULE14 - With mixed results only rejected rules get error sets
// RULE15 - A fully successful transaction carries no error encodings
// RULE16 - A response with any error set carries no other rule encodings
// RULE17 - Error encodings never go into request messages
// RULE18 - Each error set holds one one-byte errored subtype field
// RULE19 - Each error set holds one one-byte nonzero error code
// RULE20 - Error code zero is never written into an error set
// RULE21 - At most one zero-terminated text field per error set
// RULE22 - A built error encoding stays below 256 characters
// RULE23 - Missing rule reports code 16, existing rule on add code 17
// RULE24 - Byte count zero disables suppression, nonzero enables it
// RULE25 - An action byte above 3 is rejected naming the action subtype
`ifndef PHSR_CONSTS_SVH
`define PHSR_CONSTS_SVH
`define PHSR_TYPE_RULE 8'h1a
`define PHSR_SUB_ERR 8'h06
`define PHSR_SUB_CREF 8'h01
`define PHSR_SUB_CID 8'h02
`define PHSR_SUB_SFREF 8'h03
`define PHSR_SUB_SFID 8'h04
`define PHSR_SUB_ACT 8'h05
`define PHSR_SUB_HDR 8'h07
`define PHSR_SUB_CNT 8'h0a
`define PHSR_ESUB_PARAM 8'h01
`define PHSR_ESUB_CODE 8'h02
`define PHSR_RULE_MAXTOT 9'h0fe
`define PHSR_ERR_LEN 8'h06
`define PHSR_ACT_ADD 8'h00
`define PHSR_ACT_FILL 8'h01
`define PHSR_ACT_DEL 8'h02
`define PHSR_ACT_DELALL 8'h03
`define PHSR_CC_UNRECOG 8'h02
`define PHSR_CC_RESOURCE 8'h03
`define PHSR_CC_HDRSUP 8'h09
`define PHSR_CC_NOTFOUND 8'h10
`define PHSR_CC_EXISTS 8'h11
`define PHSR_OFS_CTRL 12'h000
`define PHSR_OFS_STAT 12'h004
`define PHSR_OFS_RULES 12'h008
`define PHSR_OFS_NOK 12'h00c
`define PHSR_OFS_NREJ 12'h010
`define PHSR_CTRL_RST 3'h4
`define PHSR_KIND_DSC 2'h2
`define PHSR_KIND_BAD 2'h3
`endif

// *** design/phsr_pkg.sv ***
// Types of the header suppression rule command interpreter
package phsr_pkg;
  typedef enum logic [3:0] {
    PHSR_IDLE = 4'h1,
    PHSR_PARSE = 4'h2,
    PHSR_EXEC = 4'h4,
    PHSR_EMIT = 4'h8
  } phsr_state_e;
  typedef struct packed {
    logic valid;
    logic hdr_k;
    logic cnt_k;
    logic [7:0] scnt;
    logic [15:0] cid;
    logic [31:0] sfid;
  } phsr_rule_s;
endpackage

// *** dv/phsr_peer.sv ***
// Peer message engine model: feeds rule sets, sinks error sets
`timescale 1ns/1ps
`default_nettype none
module phsr_peer
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_rx_ready,
  input wire logic i_err_valid,
  input wire logic [7:0] i_err_data,
  input wire logic i_err_last,
  input wire logic i_stall,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_last,
  output logic o_err_ready
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  int last_at;
  // ---------------------------------------------------------------
  // Byte source and error sink
  // ---------------------------------------------------------------
  // Idle data line inverts every cycle so stale bytes never look valid
  always @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_last <= 1'b0;
      o_err_ready <= 1'b0;
    end
    else
    begin
      if (o_rx_valid && i_rx_ready)
        void'(tx_q.pop_front());
      o_rx_valid <= tx_q.size() != 0;
      o_rx_data <= (tx_q.size() != 0) ? tx_q[0] : ~o_rx_data;
      o_rx_last <= tx_q.size() == 1;
      if (i_err_valid && o_err_ready)
      begin
        rx_q.push_back(i_err_data);
        if (i_err_last)
          last_at = rx_q.size();
      end
      // Stalling sink drops ready every other cycle
      o_err_ready <= i_stall ? ~o_err_ready : 1'b1;
    end
  end
endmodule // phsr_peer
`default_nettype wire

// *** dv/header_suppression_rule_tlv_tb.sv ***
// Self-checking bench for the rule interpreter
`timescale 1ns/1ps
`default_nettype none
`include "phsr_consts.svh"
module header_suppression_rule_tlv_tb;
  logic i_clk_sys, i_rst_b, psel, pen, pwr, pready, pslverr, pe;
  logic txn, rx_valid, rx_last, rx_ready, err_valid, err_last;
  logic err_ready, stall, inhibit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx_data, err_data;
  logic [1:0] rsp_kind;
  logic [3:0] sup_en;
  logic [7:0] k[$];
  logic [7:0] b[$];
  int mismatches, n_compared, n_ok, n_rej;
  phsr_top i_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_txn_start(txn), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_last(rx_last), .o_rx_ready(rx_ready),
    .o_err_valid(err_valid), .o_err_data(err_data),
    .o_err_last(err_last), .i_err_ready(err_ready),
    .o_err_rsp_kind(rsp_kind), .o_rsp_echo_inhibit(inhibit),
    .o_suppress_en(sup_en));
  phsr_peer i_peer (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_rx_ready(rx_ready), .i_err_valid(err_valid),
    .i_err_data(err_data), .i_err_last(err_last), .i_stall(stall),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_last(rx_last),
    .o_err_ready(err_ready));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task automatic timeout();
  begin
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    final_report();
  end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // APB master; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
  begin
    @(posedge i_clk_sys);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    pen <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      timeout();
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  end
  endtask
  // New transaction with a given message kind and enable
  task automatic start(input logic [31:0] ctrl);
  begin
    apb(1'b1, `PHSR_OFS_CTRL, ctrl);
    txn <= 1'b1;
    @(posedge i_clk_sys);
    txn <= 1'b0;
    @(negedge i_clk_sys);
    chk(inhibit, 1'b0);
  end
  endtask
  // One rule set through the peer; code zero means it must be accepted
  task automatic run(input logic [7:0] q[$], input logic [7:0] sub,
    input logic [7:0] code);
    int n;
    logic [7:0] x[$];
  begin
    i_peer.rx_q.delete();
    i_peer.last_at = 0;
    i_peer.tx_q = q;
    for (n = 0; n < 400 && i_peer.tx_q.size() != 0; n++)
      @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    for (n = n; n < 440 && err_valid !== 1'b0; n++)
      @(negedge i_clk_sys);
    if (n >= 400)
      timeout();
    if (code != 8'h00)
    begin
      x = {8'h06, 8'h06, 8'h01, 8'h01, sub, 8'h02, 8'h01, code};
      chk(i_peer.last_at, 8);
      n_rej++;
    end
    else
      n_ok++;
    chk(i_peer.rx_q.size(), x.size());
    foreach (x[i])
      if (i != 4 || sub != 8'h00)
        chk(i_peer.rx_q[i], x[i]);
  end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
  begin
    apb(1'b0, `PHSR_OFS_CTRL, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk(pe, 1'b1);
  end
  endtask
  // Add in change request, then add again in an add response
  task automatic t_add();
  begin
    start(32'h6);
    run({k, 8'h05, 8'h01, 8'h00, 8'h07, 8'h02, 8'ha5, 8'h5a,
      8'h0a, 8'h01, 8'h02}, 8'h00, 8'h00);
    chk(inhibit, 1'b0);
    chk(|sup_en, 1'b1);
    start(32'h5);
    run({k, 8'h07, 8'h02, 8'ha5, 8'h5a, 8'h0a, 8'h01, 8'h02}, 8'h05,
      `PHSR_CC_EXISTS);
    chk(rsp_kind, 2'h1);
    chk(inhibit, 1'b1);
  end
  endtask
  // Fill, delete and bad actions with a stalling sink
  task automatic t_fill();
  begin
    stall <= 1'b1;
    start(32'h6);
    run({k, 8'h05, 8'h01, 8'h01, 8'h0a, 8'h01, 8'h02}, 8'h0a,
      `PHSR_CC_HDRSUP);
    run({k[4:$], 8'h05, 8'h01, 8'h03}, 8'h00, 8'h00);
    chk(sup_en, 4'h0);
    chk(inhibit, 1'b1);
    run({k, 8'h05, 8'h01, 8'h02}, 8'h05, `PHSR_CC_NOTFOUND);
    run({k, 8'h05, 8'h01, 8'h00, 8'h0a, 8'h01, 8'h02}, 8'h00, 8'h00);
    chk(sup_en, 4'h0);
    run({k, 8'h05, 8'h01, 8'h01, 8'h07, 8'h02, 8'ha5, 8'h5a}, 8'h00,
      8'h00);
    chk(|sup_en, 1'b1);
    run({k, 8'h05, 8'h01, 8'h04}, 8'h05, `PHSR_CC_UNRECOG);
    stall <= 1'b0;
  end
  endtask
  // Out-of-range values, nested error encoding and an over-long set
  task automatic t_range();
  begin
    start(32'h4);
    run({8'h01, 8'h01, 8'h00, k[4:$]}, 8'h01, `PHSR_CC_UNRECOG);
    run({8'h02, 8'h02, 8'h00, 8'h00, k[4:$]}, 8'h02,
      `PHSR_CC_UNRECOG);
    run({8'h03, 8'h02, 8'h00, 8'h00, k[0:3]}, 8'h03,
      `PHSR_CC_UNRECOG);
    run({k[0:3], 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h04,
      `PHSR_CC_UNRECOG);
    run({k, 8'h06, 8'h01, 8'h00}, 8'h06, `PHSR_CC_UNRECOG);
    b = {k, 8'h07, 8'hf3};
    repeat (243) b.push_back(8'h5a);
    run(b, `PHSR_TYPE_RULE, `PHSR_CC_UNRECOG);
    chk(rsp_kind, 2'h0);
  end
  endtask
  // Disabled interpreter and invalid kind never take bytes
  task automatic t_refuse(input logic [31:0] ctrl);
    logic seen;
  begin
    apb(1'b1, `PHSR_OFS_CTRL, ctrl);
    i_peer.tx_q = k;
    seen = 1'b0;
    repeat (6) @(negedge i_clk_sys) seen = seen | rx_ready;
    chk(seen, 1'b0);
    i_peer.tx_q.delete();
    @(negedge i_clk_sys);
  end
  endtask
  task automatic t_counts();
  begin
    apb(1'b0, `PHSR_OFS_NOK, 32'h0);
    chk(rd & 32'hffff, n_ok);
    apb(1'b0, `PHSR_OFS_NREJ, 32'h0);
    chk(rd & 32'hffff, n_rej);
  end
  endtask
  // ---------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    i_rst_b = 1'b0;
    {psel, pen, pwr, txn, stall} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    k = {8'h02, 8'h02, 8'h00, 8'h11, 8'h04, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h22};
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_regs();
    t_add();
    t_fill();
    t_range();
    t_refuse(32'h2);
    t_refuse(32'h7);
    t_counts();
    final_report();
  end
endmodule // header_suppression_rule_tlv_tb
`default_nettype wire
